// file: bench/dma_event_sync_capture_sva.sv
// assertions on the ports of the event capture front end
`timescale 1ns/100ps
`default_nettype none
module dma_event_sync_capture_sva (
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_wide_mem_refresh_irq,
    input wire logic        i_narrow_mem_refresh_irq,
    input wire logic [3:0]  i_pin_event,
    input wire logic [63:0] i_latch_clear,
    input wire logic        i_req_ready,
    input wire logic        o_req_valid,
    input wire logic [5:0]  o_req_chan,
    input wire logic [1:0]  o_req_prio,
    input wire logic [31:0] o_event_latch_low
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_hold; o_req_valid && !i_req_ready |=> o_req_valid
        && $stable(o_req_chan) && $stable(o_req_prio); endproperty
    property p_gap; o_req_valid && i_req_ready |=> !o_req_valid; endproperty
    property p_wide; $rose(i_wide_mem_refresh_irq) |=>
        o_event_latch_low[3]; endproperty
    property p_narrow; $rose(i_narrow_mem_refresh_irq) |=>
        o_event_latch_low[20]; endproperty
    property p_pin; $rose(i_pin_event[0]) ##1 i_pin_event[0] [*3] |->
        o_event_latch_low[4]; endproperty
    property p_none; !o_event_latch_low[16]
        && o_event_latch_low[27:21] == 7'h00; endproperty
    property p_chan; o_req_valid |-> o_req_chan != 6'h10; endproperty
    property p_sticky; o_event_latch_low[3] && !i_latch_clear[3]
        && !(o_req_valid && i_req_ready) |=> o_event_latch_low[3]; endproperty
    a_hold: assert property (p_hold)
        else $error("request moved while stalled");
    a_gap: assert property (p_gap)
        else $error("no idle cycle after grant");
    a_wide: assert property (p_wide)
        else $error("wide refresh event not latched");
    a_narrow: assert property (p_narrow)
        else $error("narrow refresh event not latched");
    a_pin: assert property (p_pin)
        else $error("pin event not latched");
    a_none: assert property (p_none)
        else $error("sourceless channel latched");
    a_chan: assert property (p_chan)
        else $error("sourceless channel requested");
    a_sticky: assert property (p_sticky)
        else $error("latch dropped on its own");
    // main scenarios
    c_grant: cover property (o_req_valid && i_req_ready);
    c_stall: cover property (o_req_valid && !i_req_ready [*3]);
    c_pin: cover property ($rose(i_pin_event[0]));
endmodule // dma_event_sync_capture_sva
bind dma_event_sync_capture dma_event_sync_capture_sva i_sva (
    .i_core_clk               (i_core_clk),
    .i_nrst                   (i_nrst),
    .i_wide_mem_refresh_irq   (i_wide_mem_refresh_irq),
    .i_narrow_mem_refresh_irq (i_narrow_mem_refresh_irq),
    .i_pin_event              (i_pin_event),
    .i_latch_clear            (i_latch_clear),
    .i_req_ready              (i_req_ready),
    .o_req_valid              (o_req_valid),
    .o_req_chan               (o_req_chan),
    .o_req_prio               (o_req_prio),
    .o_event_latch_low        (o_event_latch_low)
);
`default_nettype wire

// file: bench/dma_event_sync_capture_tb.sv
// self-checking bench for the event capture front end
`timescale 1ns/100ps
`default_nettype none
module dma_event_sync_capture_tb;
    import dma_event_pkg::*;
    logic i_core_clk = 1'b0, i_nrst = 1'b0, i_param_wr, i_req_ready;
    logic i_host_irq, i_timer0_irq, i_timer1_irq, i_timer2_irq, o_req_valid;
    logic i_wide_mem_refresh_irq, i_narrow_mem_refresh_irq;
    logic [5:0]  i_serial_events, i_param_chan, o_req_chan;
    logic [35:0] i_upper_events;
    logic [3:0]  i_pin_event, i_gpio_event;
    logic [31:0] i_event_enable_low, i_event_enable_high;
    logic [31:0] o_event_latch_low, o_event_latch_high;
    logic [63:0] i_latch_clear, fire, exp, en;
    logic [55:0] src;
    logic [1:0]  i_param_prio, o_req_prio, pr [5];
    logic [7:0]  q [$];
    int error_cnt = 0, num_checks = 0, cyc = 0, set [5] = '{1, 3, 19, 20, 40};
    assign {i_upper_events, i_narrow_mem_refresh_irq, i_timer2_irq,
            i_serial_events, i_gpio_event, i_pin_event, i_wide_mem_refresh_irq,
            i_timer1_irq, i_timer0_irq, i_host_irq} = src;
    assign {i_event_enable_high, i_event_enable_low} = en;
    event_source_model i_src (.i_fire(fire), .o_src(src));
    dma_event_sync_capture i_dut (
        .i_core_clk               (i_core_clk),
        .i_nrst                   (i_nrst),
        .i_host_irq               (i_host_irq),
        .i_timer0_irq             (i_timer0_irq),
        .i_timer1_irq             (i_timer1_irq),
        .i_timer2_irq             (i_timer2_irq),
        .i_wide_mem_refresh_irq   (i_wide_mem_refresh_irq),
        .i_narrow_mem_refresh_irq (i_narrow_mem_refresh_irq),
        .i_serial_events          (i_serial_events),
        .i_upper_events           (i_upper_events),
        .i_pin_event              (i_pin_event),
        .i_gpio_event             (i_gpio_event),
        .i_event_enable_low       (i_event_enable_low),
        .i_event_enable_high      (i_event_enable_high),
        .i_latch_clear            (i_latch_clear),
        .i_param_wr               (i_param_wr),
        .i_param_chan             (i_param_chan),
        .i_param_prio             (i_param_prio),
        .o_req_valid              (o_req_valid),
        .o_req_chan               (o_req_chan),
        .o_req_prio               (o_req_prio),
        .i_req_ready              (i_req_ready),
        .o_event_latch_low        (o_event_latch_low),
        .o_event_latch_high       (o_event_latch_high)
    );
    always #2.5 i_core_clk = ~i_core_clk;
    task automatic chk_lat(input logic [63:0] e);
        num_checks++;
        if ({o_event_latch_high, o_event_latch_low} !== e) begin
            error_cnt++;
            $display("MISMATCH %0t latch %h", $time,
                     {o_event_latch_high, o_event_latch_low});
        end
    endtask
    task automatic chk_req(input logic [7:0] e);
        num_checks++;
        if ({o_req_chan, o_req_prio} !== e) begin
            error_cnt++;
            $display("MISMATCH %0t request %h", $time,
                     {o_req_chan, o_req_prio});
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // scoreboard: oldest expected request against each grant
    always @(posedge i_core_clk)
        if (i_nrst && o_req_valid && i_req_ready)
            chk_req(q.size() ? q.pop_front() : 8'hxx);
    // hang guard
    always @(posedge i_core_clk) if (++cyc == 3000) begin
        error_cnt++;
        final_report;
    end
    // stimulus, driven on the falling edge
    initial begin
        fire = '0; en = '0; i_latch_clear = '0; i_param_wr = 1'b0;
        i_param_chan = '0; i_param_prio = '0; i_req_ready = 1'b1;
        void'($urandom(25));
        repeat (10) @(negedge i_core_clk);
        i_nrst = 1'b1;
        @(negedge i_core_clk);
        chk_lat(64'h0);
        // every channel alone, all disabled, then cleared
        for (int c = 0; c < 64; c++) begin
            fire[c] = 1'b1;
            repeat (4) @(negedge i_core_clk);
            fire[c] = 1'b0;
            repeat (2) @(negedge i_core_clk);
            exp = '0;
            exp[c] = !(c == 16 || (c > 20 && c < 28));
            chk_lat(exp);
            i_latch_clear = '1;
            @(negedge i_core_clk);
            i_latch_clear = '0;
        end
        // random priorities, stalled engine, repeat edge on ch1
        i_req_ready = 1'b0;
        en = '1;
        foreach (set[i]) begin
            pr[i] = 2'($urandom);
            i_param_wr = 1'b1; i_param_chan = 6'(set[i]); i_param_prio = pr[i];
            @(negedge i_core_clk);
        end
        i_param_wr = 1'b0;
        for (int p = 0; p < 4; p++)
            foreach (set[i]) if (pr[i] == p) q.push_back({6'(set[i]), pr[i]});
        foreach (set[i]) fire[set[i]] = 1'b1;
        repeat (4) @(negedge i_core_clk);
        fire = '0;
        repeat (2) @(negedge i_core_clk);
        fire[1] = 1'b1;
        repeat (4) @(negedge i_core_clk);
        fire = '0;
        i_req_ready = 1'b1;
        repeat (30) @(negedge i_core_clk);
        chk_lat(64'h0);
        if (q.size() != 0) chk_req(8'hxx);
        // edge and clear on one edge: the edge wins; disabled, no request
        en = '0;
        fire[2] = 1'b1;
        i_latch_clear = '1;
        @(negedge i_core_clk);
        i_latch_clear = '0;
        repeat (3) @(negedge i_core_clk);
        chk_lat(64'h4);
        // reset in mid-run drops a stalled request and every latch
        i_req_ready = 1'b0;
        en = '1;
        repeat (3) @(negedge i_core_clk);
        i_nrst = 1'b0;
        fire = '0;
        repeat (3) @(negedge i_core_clk);
        i_nrst = 1'b1;
        i_req_ready = 1'b1;
        repeat (4) @(negedge i_core_clk);
        chk_lat(64'h0);
        final_report;
    end
endmodule // dma_event_sync_capture_tb
`default_nettype wire

// file: bench/event_source_model.sv
// peripheral event sources feeding the capture front end
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
    input  wire logic [63:0] i_fire,
    output logic      [55:0] o_src
);
    // one fire bit per channel; channels with no source are dropped
    assign o_src = {i_fire[63:28], i_fire[20:17], i_fire[15:0]};
endmodule // event_source_model
`default_nettype wire

// file: rtl/dma_event_pkg.sv
// constants shared by the event capture front end
`default_nettype none
package dma_event_pkg;
    localparam int NUM_CHANNELS   = 64;
    localparam int CHAN_W         = 6;
    localparam int PRIO_W         = 2;
    localparam int SYNC_STAGES    = 2;
    // fixed channel numbers of the hard-wired event sources
    localparam int CH_HOST_IRQ    = 0;
    localparam int CH_TIMER0      = 1;
    localparam int CH_TIMER1      = 2;
    localparam int CH_WIDE_REFR   = 3;
    localparam int CH_PIN_EV_LO   = 4;
    localparam int CH_PIN_EV_HI   = 7;
    localparam int CH_GPIO_LO     = 8;
    localparam int CH_GPIO_HI     = 11;
    localparam int CH_SER_LO      = 12;
    localparam int CH_SER_NONE    = 16;
    localparam int CH_SER_HI      = 18;
    localparam int CH_TIMER2      = 19;
    localparam int CH_NARROW_REFR = 20;
    localparam int CH_UPPER_LO    = 28;
    // widths of the grouped event inputs
    localparam int PIN_EV_W       = 4;
    localparam int GPIO_W         = 4;
    localparam int SER_W          = 6;
    localparam int UPPER_W        = 36;
    // values after reset
    localparam logic [PRIO_W-1:0] PRIO_RESET  = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_RESET  = 6'h00;
    localparam logic [31:0]       LATCH_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// file: rtl/dma_event_sync_capture.sv
// event capture, channel mapping and priority pick for the dma controller
`timescale 1ns/100ps
`default_nettype none
module dma_event_sync_capture #(
    parameter int NCH = dma_event_pkg::NUM_CHANNELS
) (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_nrst,
    // on-chip event sources, same clock
    input  wire logic                              i_host_irq,
    input  wire logic                              i_timer0_irq,
    input  wire logic                              i_timer1_irq,
    input  wire logic                              i_timer2_irq,
    input  wire logic                              i_wide_mem_refresh_irq,
    input  wire logic                              i_narrow_mem_refresh_irq,
    input  wire logic [dma_event_pkg::SER_W-1:0]   i_serial_events,
    input  wire logic [dma_event_pkg::UPPER_W-1:0] i_upper_events,
    // pin-borne events, asynchronous
    input  wire logic [dma_event_pkg::PIN_EV_W-1:0] i_pin_event,
    input  wire logic [dma_event_pkg::GPIO_W-1:0]   i_gpio_event,
    // enables and software clears
    input  wire logic [31:0]                       i_event_enable_low,
    input  wire logic [31:0]                       i_event_enable_high,
    input  wire logic [63:0]                       i_latch_clear,
    // parameter ram priority write port
    input  wire logic                              i_param_wr,
    input  wire logic [dma_event_pkg::CHAN_W-1:0]  i_param_chan,
    input  wire logic [dma_event_pkg::PRIO_W-1:0]  i_param_prio,
    // service request to the transfer engine
    output logic                                   o_req_valid,
    output logic      [dma_event_pkg::CHAN_W-1:0]  o_req_chan,
    output logic      [dma_event_pkg::PRIO_W-1:0]  o_req_prio,
    input  wire logic                              i_req_ready,
    // captured event state
    output logic      [31:0]                       o_event_latch_low,
    output logic      [31:0]                       o_event_latch_high
);
    import dma_event_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PIN_EV_W-1:0] pin_event_s;
    logic [GPIO_W-1:0]   gpio_event_s;

    pin_sync #(.WIDTH(PIN_EV_W + GPIO_W)) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_async    ({i_gpio_event, i_pin_event}),
        .o_sync     ({gpio_event_s, pin_event_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // fixed event to channel map
    logic [NCH-1:0] event_level;

    always_comb begin
        event_level                   = '0;             // unused rows idle
        event_level[CH_HOST_IRQ]      = i_host_irq;
        event_level[CH_TIMER0]        = i_timer0_irq;
        event_level[CH_TIMER1]        = i_timer1_irq;
        event_level[CH_WIDE_REFR]     = i_wide_mem_refresh_irq;
        event_level[CH_PIN_EV_HI:CH_PIN_EV_LO] = pin_event_s;
        event_level[CH_GPIO_HI:CH_GPIO_LO]     = gpio_event_s;
        event_level[CH_SER_NONE-1:CH_SER_LO]   = i_serial_events[3:0];
        event_level[CH_SER_HI:CH_SER_NONE+1]   = i_serial_events[5:4];
        event_level[CH_TIMER2]        = i_timer2_irq;
        event_level[CH_NARROW_REFR] = i_narrow_mem_refresh_irq;
        event_level[NCH-1:CH_UPPER_LO] = i_upper_events;
    end

    ////////////////////////////////////////////////////////////////////////
    // rising edge detect and event latches
    logic [NCH-1:0] event_prev;
    logic [NCH-1:0] event_latch;
    logic [NCH-1:0] enable_mask;
    logic [NCH-1:0] service_clr;
    logic [NCH-1:0] event_rise;
    logic [NCH-1:0] latch_clr;

    assign enable_mask = {i_event_enable_high, i_event_enable_low};

    // a level that was low at the last edge is a new event
    assign event_rise = event_level & ~event_prev;

    // software or service clear; a new edge still wins
    assign latch_clr = i_latch_clear | service_clr;

    // previous level of every source
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            event_prev <= '0;
        end else begin
            event_prev <= event_level;
        end
    end

    // one latch per channel, set wins over clear
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_latch
            always_ff @(posedge i_core_clk) begin
                if (!i_nrst) begin
                    event_latch[g] <= 1'b0;
                end else if (event_rise[g]) begin
                    event_latch[g] <= 1'b1;
                end else if (latch_clr[g]) begin
                    event_latch[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_event_latch_low  = event_latch[31:0];
    assign o_event_latch_high = event_latch[63:32];

    ////////////////////////////////////////////////////////////////////////
    // parameter ram: priority per channel
    logic [PRIO_W-1:0] prio_ram [NCH];
    logic [NCH-1:0]    prio_wr;

    // one-hot write strobe from the channel number
    always_comb begin
        prio_wr = '0;
        if (i_param_wr) begin
            prio_wr[i_param_chan] = 1'b1;
        end
    end

    // one priority entry per channel, each written only by its strobe
    generate
        for (g = 0; g < NCH; g++) begin : g_prio
            always_ff @(posedge i_core_clk) begin
                if (!i_nrst) begin
                    prio_ram[g] <= PRIO_RESET;
                end else if (prio_wr[g]) begin
                    prio_ram[g] <= i_param_prio;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pick enabled pending event: lowest priority code, then lowest channel
    logic [NCH-1:0]    pending;
    logic              next_found;
    logic [CHAN_W-1:0] next_chan;
    logic [PRIO_W-1:0] next_prio;

    assign pending = event_latch & enable_mask;

    always_comb begin
        next_found = 1'b0;
        next_chan  = CHAN_RESET;
        next_prio  = PRIO_RESET;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (pending[c] && (!next_found || prio_ram[c] <= next_prio)) begin
                next_found = 1'b1;
                next_chan  = CHAN_W'(c);
                next_prio  = prio_ram[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request register; drops for one cycle after each grant
    logic grant;

    assign grant = o_req_valid && i_req_ready;

    // valid loads while idle and drops for one cycle on grant
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_req_valid <= 1'b0;
        end else if (grant) begin
            o_req_valid <= 1'b0;
        end else if (!o_req_valid) begin
            o_req_valid <= next_found;
        end
    end

    // channel and priority follow the pick only while idle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_req_chan <= CHAN_RESET;
            o_req_prio <= PRIO_RESET;
        end else if (!o_req_valid) begin
            o_req_chan <= next_chan;
            o_req_prio <= next_prio;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stale request: its latch was dropped while it stood, so a later
    // edge on that channel is a fresh event the grant must not eat
    logic req_stale;

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            req_stale <= 1'b0;
        end else if (!o_req_valid || grant) begin
            req_stale <= 1'b0;
        end else if (!event_latch[o_req_chan]) begin
            req_stale <= 1'b1;
        end
    end

    // servicing clears the granted channel latch unless it went stale
    always_comb begin
        service_clr = '0;
        if (grant && !req_stale) begin
            service_clr[o_req_chan] = 1'b1;
        end
    end
endmodule // dma_event_sync_capture
`default_nettype wire

// file: rtl/pin_sync.sv
// two-stage synchroniser for pin-borne event inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule // pin_sync
`default_nettype wire
